// file: include/rtw_pkg.sv
// package for the reduced table translation walker
// assumes 64KB pages, 64-bit entries, physical memory reached by a read port
package rtw_pkg;
    // page geometry
    localparam int PAGE_SHIFT = 16;                // 64KB page
    localparam int L1_SHIFT = 42;                  // level1 index above level2
    localparam int L2_SHIFT = 29;                  // level2 index, 512MB page
    localparam int IDX_BITS = 13;                  // 8192 entries per table
    localparam int PTE_SHIFT = 3;                  // 8 bytes per entry
    localparam int PFN_LSB = 32;                   // frame field in entry
    localparam int PFN_BITS = 28;
    // entry bit positions
    localparam int B_VALID = 0;
    localparam int B_FOR = 1;
    localparam int B_FLT_WR = 2;
    localparam int B_FLT_EX = 3;
    localparam int B_GLOBAL = 4;
    localparam int B_HINT_LO = 5;
    localparam int B_NO_BAR = 7;
    localparam int B_K_RD = 8;
    localparam int B_U_RD = 9;
    localparam int B_K_WR = 12;
    localparam int B_U_WR = 13;
    // region select value of the two top implemented bits
    localparam logic [1:0] REDUCED_REGION = 2'h1;
    // fault type codes
    localparam logic [2:0] FT_TNV = 3'h0;
    localparam logic [2:0] FT_ACV = 3'h1;
    localparam logic [2:0] FT_FOR = 3'h2;
    localparam logic [2:0] FT_FLT_EX = 3'h3;
    localparam logic [2:0] FT_FLT_WR = 3'h4;
    // access kinds
    localparam logic [1:0] ACC_READ = 2'h0;
    localparam logic [1:0] ACC_WRITE = 2'h1;
    localparam logic [1:0] ACC_EXEC = 2'h2;
    // space tag limits and buffer entry count
    localparam int TAG_LIMIT_MIN = 13;
    localparam int TAG_LIMIT_MAX = 65535;
    localparam int TB_ENTRIES = 8;
    // walker states, gray in the order listed (IDLE, L1, L2, CHECK, DONE)
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_L1 = 3'h1,
        ST_L2 = 3'h3,
        ST_CHECK = 3'h2,
        ST_DONE = 3'h6
    } walk_e;
endpackage

// file: design/rtw_tb_store.sv
// translation buffer store: tags, frames and flags for recent translations
// assumes one write and one lookup per cycle; single clock
`timescale 1ns/1ps
module rtw_tb_store #(
    parameter int ENTRIES = 8,
    parameter int VPN_BITS = 24,
    parameter int TAG_BITS = 16,
    parameter int DATA_BITS = 64
) (
    input wire logic i_clk,                        // core clock
    input wire logic i_reset_n,                    // async reset
    input wire logic [VPN_BITS-1:0] i_look_vpn,    // lookup page
    input wire logic [TAG_BITS-1:0] i_look_tag,    // lookup space tag
    output logic o_hit,                            // registered hit
    output logic [DATA_BITS-1:0] o_data,           // registered entry
    input wire logic i_wr,                         // fill strobe
    input wire logic [VPN_BITS-1:0] i_wr_vpn,      // fill page
    input wire logic [TAG_BITS-1:0] i_wr_tag,      // fill tag
    input wire logic i_wr_global,                  // fill matches all spaces
    input wire logic [DATA_BITS-1:0] i_wr_data,    // fill entry
    input wire logic i_inv_all,                    // drop all
    input wire logic i_inv_private,                // drop non global
    input wire logic i_inv_one,                    // drop one page
    input wire logic [VPN_BITS-1:0] i_inv_vpn      // page to drop
);
    typedef struct packed {
        logic [ENTRIES-1:0] valid;
        logic [ENTRIES-1:0] global;
        logic [ENTRIES-1:0][VPN_BITS-1:0] vpn;
        logic [ENTRIES-1:0][TAG_BITS-1:0] tag;
        logic [ENTRIES-1:0][DATA_BITS-1:0] data;
        logic [$clog2(ENTRIES)-1:0] victim;
        logic hit;
        logic [DATA_BITS-1:0] rd;
    } store_s;
    store_s st_r;
    store_s st_nxt;

    // lookup, invalidate and round robin fill
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.hit = 1'b0;
        st_nxt.rd = '0;
        for (int i = 0; i < ENTRIES; i++)
        begin
            if (st_r.valid[i] && st_r.vpn[i] == i_look_vpn &&
                (st_r.global[i] || st_r.tag[i] == i_look_tag))
            begin
                st_nxt.hit = 1'b1;
                st_nxt.rd = st_r.data[i];
            end
            if (i_inv_all || (i_inv_private && !st_r.global[i]) ||
                (i_inv_one && st_r.vpn[i] == i_inv_vpn))
                st_nxt.valid[i] = 1'b0;
        end
        if (i_wr)
        begin
            st_nxt.valid[st_r.victim] = 1'b1;
            st_nxt.global[st_r.victim] = i_wr_global;
            st_nxt.vpn[st_r.victim] = i_wr_vpn;
            st_nxt.tag[st_r.victim] = i_wr_tag;
            st_nxt.data[st_r.victim] = i_wr_data;
            st_nxt.victim = st_r.victim + 1'b1;
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign o_hit = st_r.hit;
    assign o_data = st_r.rd;
endmodule

// file: design/reduced_table_translation_walker.sv
// two-level walker for the reduced table region with translation buffer
// assumes a memory read port with one-cycle-or-more latency, single clock
`timescale 1ns/1ps
module reduced_table_translation_walker #(
    parameter int VA_SIZE = 48,                    // implemented va width
    parameter int TAG_BITS = 16,
    parameter logic [15:0] SPACE_TAG_LIMIT = 16'h00ff,
    parameter bit HAS_SPACE_TAGS = 1'b1
) (
    input wire logic i_clk,                        // core clock
    input wire logic i_reset_n,                    // async reset, active low
    input wire logic i_req,                        // access request
    input wire logic [63:0] i_va,                  // virtual address
    input wire logic [1:0] i_access,               // read, write or execute
    input wire logic i_current_mode_bit,           // 1 user, 0 kernel
    output logic o_busy,                           // walker not idle
    output logic o_done,                           // translation answered
    output logic o_fault,                          // fault with done
    output logic [2:0] o_fault_type_code,          // fault kind
    output logic [63:0] o_pa,                      // physical address
    output logic o_ordinary_walk,                  // use ordinary walk
    output logic o_no_barrier_flag,                // flag of translation
    input wire logic i_reduced_table_mode_avail,   // feature present
    input wire logic i_reduced_table_mode_en,      // feature enabled
    input wire logic i_boundary_in_use,            // boundary register used
    input wire logic [63:0] i_virtual_boundary,    // boundary value
    input wire logic [27:0] i_table_base,          // primary base frame
    input wire logic [27:0] i_system_table_base,   // alternate base frame
    input wire logic [TAG_BITS-1:0] i_space_tag,   // current space tag
    input wire logic i_space_tag_load,             // context swap tag load
    input wire logic i_inv_all,                    // invalidate whole buffer
    input wire logic i_inv_private,                // invalidate non global
    input wire logic i_inv_one,                    // invalidate one page
    input wire logic [63:0] i_inv_va,              // page to invalidate
    output logic o_tag_out_of_range,               // tag above limit
    output logic o_mem_req,                        // table read request
    output logic [63:0] o_mem_addr,                // table entry address
    input wire logic i_mem_ack,                    // read data valid
    input wire logic [63:0] i_mem_data             // entry read back
);
    localparam int VPN_BITS = VA_SIZE - rtw_pkg::L2_SHIFT;

    typedef struct packed {
        rtw_pkg::walk_e state;
        logic [63:0] va;
        logic [1:0] access;
        logic user;
        logic [63:0] pte;
        logic lookup;
        logic done;
        logic fault;
        logic [2:0] code;
        logic [63:0] pa;
        logic ordinary;
        logic no_bar;
        logic fill;
    } walk_s;
    walk_s w_r;
    walk_s w_nxt;

    logic tb_hit;
    logic [63:0] tb_data;
    logic canon_ok;
    logic in_region;
    logic [27:0] base;

    // address of an entry: frame*page plus 8*index
    function automatic logic [63:0] entry_addr(input logic [27:0] frame,
                                               input logic [12:0] idx);
        entry_addr = {20'h0, frame, 16'h0} | {48'h0, idx, 3'h0};
    endfunction

    function automatic logic [VPN_BITS-1:0] vpn_of(input logic [63:0] va);
        vpn_of = va[VA_SIZE-1:rtw_pkg::L2_SHIFT];
    endfunction

    // fault check of a second level entry; returns {fault, code}
    function automatic logic [3:0] check_l2(input logic [63:0] p, input logic [1:0] acc,
                                            input logic user);
        logic rd;
        logic wr;
        logic deny;
        rd = (acc != rtw_pkg::ACC_WRITE);
        wr = (acc == rtw_pkg::ACC_WRITE);
        deny = (user && wr && !p[rtw_pkg::B_U_WR]) || (user && rd && !p[rtw_pkg::B_U_RD]) ||
               (!user && wr && !p[rtw_pkg::B_K_WR]) || (!user && rd && !p[rtw_pkg::B_K_RD]);
        if (deny)
            check_l2 = {1'b1, rtw_pkg::FT_ACV};
        else if (!p[rtw_pkg::B_VALID])
            check_l2 = {1'b1, rtw_pkg::FT_TNV};
        else if (wr && p[rtw_pkg::B_FLT_WR])
            check_l2 = {1'b1, rtw_pkg::FT_FLT_WR};
        else if (acc == rtw_pkg::ACC_READ && p[rtw_pkg::B_FOR])
            check_l2 = {1'b1, rtw_pkg::FT_FOR};
        else if (acc == rtw_pkg::ACC_EXEC && p[rtw_pkg::B_FLT_EX])
            check_l2 = {1'b1, rtw_pkg::FT_FLT_EX};
        else
            check_l2 = {1'b0, rtw_pkg::FT_TNV};
    endfunction

    // sign extension, region and base selection
    always_comb
    begin
        canon_ok = (i_va == {{(64-VA_SIZE){i_va[VA_SIZE-1]}}, i_va[VA_SIZE-1:0]});
        in_region = (i_va[VA_SIZE-1:VA_SIZE-2] == rtw_pkg::REDUCED_REGION);
        if (i_boundary_in_use && !(i_va < i_virtual_boundary))
            base = i_system_table_base;
        else
            base = i_table_base;
    end

    // translation buffer, tagged by space tag unless tags are absent
    rtw_tb_store #(
        .ENTRIES(rtw_pkg::TB_ENTRIES),
        .VPN_BITS(VPN_BITS),
        .TAG_BITS(TAG_BITS),
        .DATA_BITS(64)
    ) u_store (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_look_vpn(vpn_of(w_r.va)),
        .i_look_tag(HAS_SPACE_TAGS ? i_space_tag : '0),
        .o_hit(tb_hit),
        .o_data(tb_data),
        .i_wr(w_r.fill),
        .i_wr_vpn(vpn_of(w_r.va)),
        .i_wr_tag(HAS_SPACE_TAGS ? i_space_tag : '0),
        .i_wr_global(w_r.pte[rtw_pkg::B_GLOBAL]),
        .i_wr_data(w_r.pte),
        .i_inv_all(i_inv_all),
        .i_inv_private(i_inv_private || (!HAS_SPACE_TAGS && i_space_tag_load)),
        .i_inv_one(i_inv_one),
        .i_inv_vpn(vpn_of(i_inv_va))
    );

    // walker sequence
    always_comb
    begin
        logic [3:0] chk;
        chk = '0;
        w_nxt = w_r;
        w_nxt.done = 1'b0;
        w_nxt.fill = 1'b0;
        case (w_r.state)
            rtw_pkg::ST_IDLE:
            begin
                if (i_req)
                begin
                    w_nxt.va = i_va;
                    w_nxt.access = i_access;
                    w_nxt.user = i_current_mode_bit;
                    w_nxt.fault = 1'b0;
                    w_nxt.ordinary = 1'b0;
                    w_nxt.no_bar = 1'b0;
                    w_nxt.pa = '0;
                    w_nxt.code = rtw_pkg::FT_TNV;
                    if (!canon_ok)
                    begin
                        w_nxt.fault = 1'b1;
                        w_nxt.code = rtw_pkg::FT_ACV;
                        w_nxt.state = rtw_pkg::ST_DONE;
                    end
                    else if (!(in_region && i_reduced_table_mode_avail &&
                               i_reduced_table_mode_en))
                    begin
                        w_nxt.ordinary = 1'b1;
                        w_nxt.state = rtw_pkg::ST_DONE;
                    end
                    else
                    begin
                        w_nxt.pte = entry_addr(base,
                            i_va[rtw_pkg::L1_SHIFT +: rtw_pkg::IDX_BITS]);
                        w_nxt.lookup = 1'b1;
                        w_nxt.state = rtw_pkg::ST_CHECK;
                    end
                end
            end
            rtw_pkg::ST_CHECK:
            begin
                // buffer answer arrives one cycle after lookup
                if (w_r.lookup)
                    w_nxt.lookup = 1'b0;
                else if (tb_hit)
                begin
                    chk = check_l2(tb_data, w_r.access, w_r.user);
                    w_nxt.fault = chk[3];
                    w_nxt.code = chk[2:0];
                    w_nxt.no_bar = tb_data[rtw_pkg::B_NO_BAR];
                    w_nxt.pa = {20'h0, tb_data[rtw_pkg::PFN_LSB +: rtw_pkg::PFN_BITS], 16'h0} |
                               {35'h0, w_r.va[rtw_pkg::L2_SHIFT-1:0]};
                    w_nxt.state = rtw_pkg::ST_DONE;
                end
                else
                    w_nxt.state = rtw_pkg::ST_L1;
            end
            rtw_pkg::ST_L1:
            begin
                if (i_mem_ack)
                begin
                    if (!i_mem_data[rtw_pkg::B_VALID])
                    begin
                        w_nxt.fault = 1'b1;
                        w_nxt.code = i_mem_data[rtw_pkg::B_K_RD] ? rtw_pkg::FT_TNV
                                                                : rtw_pkg::FT_ACV;
                        w_nxt.state = rtw_pkg::ST_DONE;
                    end
                    else
                    begin
                        w_nxt.pte = entry_addr(i_mem_data[rtw_pkg::PFN_LSB +: rtw_pkg::PFN_BITS],
                            w_r.va[rtw_pkg::L2_SHIFT +: rtw_pkg::IDX_BITS]);
                        w_nxt.state = rtw_pkg::ST_L2;
                    end
                end
            end
            rtw_pkg::ST_L2:
            begin
                if (i_mem_ack)
                begin
                    chk = check_l2(i_mem_data, w_r.access, w_r.user);
                    w_nxt.fault = chk[3];
                    w_nxt.code = chk[2:0];
                    w_nxt.pte = i_mem_data;
                    w_nxt.fill = i_mem_data[rtw_pkg::B_VALID];
                    w_nxt.no_bar = i_mem_data[rtw_pkg::B_NO_BAR];
                    w_nxt.pa = {20'h0, i_mem_data[rtw_pkg::PFN_LSB +: rtw_pkg::PFN_BITS], 16'h0} |
                               {35'h0, w_r.va[rtw_pkg::L2_SHIFT-1:0]};
                    w_nxt.state = rtw_pkg::ST_DONE;
                end
            end
            rtw_pkg::ST_DONE:
            begin
                w_nxt.done = 1'b1;
                w_nxt.state = rtw_pkg::ST_IDLE;
            end
            default:
                w_nxt.state = rtw_pkg::ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            w_r <= '0;
        else
            w_r <= w_nxt;
    end

    // outputs
    assign o_busy = (w_r.state != rtw_pkg::ST_IDLE);
    assign o_done = w_r.done;
    assign o_fault = w_r.fault && w_r.done;
    assign o_fault_type_code = w_r.code;
    assign o_pa = w_r.pa;
    assign o_ordinary_walk = w_r.ordinary && w_r.done;
    assign o_no_barrier_flag = w_r.no_bar;
    assign o_mem_req = (w_r.state == rtw_pkg::ST_L1) || (w_r.state == rtw_pkg::ST_L2);
    assign o_mem_addr = w_r.pte;
    assign o_tag_out_of_range = HAS_SPACE_TAGS && (16'(i_space_tag) > SPACE_TAG_LIMIT);
endmodule

// file: bench/rtw_walker_properties.sv
// checker for the reduced table walker ports
// assumes binding to the walker top with its parameters handed on
`timescale 1ns/1ps
module rtw_walker_properties #(
    parameter int VA_SIZE = 48,
    parameter int TAG_BITS = 16,
    parameter logic [15:0] SPACE_TAG_LIMIT = 16'h00ff
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_req,
    input wire logic [63:0] i_va,
    input wire logic i_reduced_table_mode_avail,
    input wire logic i_reduced_table_mode_en,
    input wire logic i_boundary_in_use,
    input wire logic [63:0] i_virtual_boundary,
    input wire logic [27:0] i_table_base,
    input wire logic [27:0] i_system_table_base,
    input wire logic [TAG_BITS-1:0] i_space_tag,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_fault,
    input wire logic [2:0] o_fault_type_code,
    input wire logic [63:0] o_pa,
    input wire logic o_ordinary_walk,
    input wire logic o_tag_out_of_range,
    input wire logic o_mem_req,
    input wire logic [63:0] o_mem_addr,
    input wire logic i_mem_ack,
    input wire logic [63:0] i_mem_data
);
    logic take;
    logic canon_ok;
    logic reduced;
    logic [27:0] base;
    logic [63:0] l1_exp_r;
    logic [63:0] va_r;
    // ****************************************
    // request decode and expected first read
    // ****************************************
    assign take = i_req && !o_busy;
    assign canon_ok = i_va == {{(64-VA_SIZE){i_va[VA_SIZE-1]}}, i_va[VA_SIZE-1:0]};
    assign reduced = i_va[VA_SIZE-1 -: 2] == rtw_pkg::REDUCED_REGION
        && i_reduced_table_mode_avail && i_reduced_table_mode_en;
    assign base = (i_boundary_in_use && i_va >= i_virtual_boundary)
        ? i_system_table_base : i_table_base;
    // capture address and first read address at take
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            l1_exp_r <= 64'h0;
            va_r <= 64'h0;
        end
        else if (take)
        begin
            l1_exp_r <= {20'h0, base, 16'h0} | {48'h0, i_va[54:42], 3'h0};
            va_r <= i_va;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    AST_ORDINARY: assert property (take && canon_ok && !reduced
        |-> ##2 o_done && o_ordinary_walk) else $error("ordinary answer missing");
    AST_CANON: assert property (take && !canon_ok |-> !o_mem_req [*2] ##1 o_done && o_fault
        && o_fault_type_code == 3'h1) else $error("sign extension fault wrong");
    AST_L1_ADDR: assert property ($rose(o_mem_req) |-> o_mem_addr == l1_exp_r)
        else $error("first read address wrong");
    AST_L2_ADDR: assert property (o_mem_req && i_mem_ack && o_mem_addr == l1_exp_r
        && i_mem_data[0] |=> o_mem_addr == ({20'h0, $past(i_mem_data[59:32]), 16'h0}
        | {48'h0, va_r[41:29], 3'h0})) else $error("second read address wrong");
    AST_L1_ACV: assert property (o_mem_req && i_mem_ack && o_mem_addr == l1_exp_r
        && !i_mem_data[0] && !i_mem_data[8] |-> ##[1:4] o_done && o_fault
        && o_fault_type_code == 3'h1) else $error("invalid first entry not a violation");
    AST_L1_TNV: assert property (o_mem_req && i_mem_ack && o_mem_addr == l1_exp_r
        && !i_mem_data[0] && i_mem_data[8] |-> ##[1:4] o_done && o_fault
        && o_fault_type_code == 3'h0) else $error("invalid first entry not a not-valid");
    AST_PA: assert property (o_done && !o_fault && !o_ordinary_walk
        |-> o_pa[28:0] == va_r[28:0] && o_pa[63:44] == 20'h0) else $error("offset wrong");
    AST_DONE_PULSE: assert property (o_done |=> !o_done && !o_fault)
        else $error("answer longer than one cycle");
    AST_TAG_RANGE: assert property (o_tag_out_of_range == (i_space_tag > SPACE_TAG_LIMIT))
        else $error("tag range flag wrong");
endmodule

// file: bench/rtw_table_memory.sv
// behavioural page table memory answering walker reads
// assumes reads held until acknowledged; entries loaded by the bench
`timescale 1ns/1ps
module rtw_table_memory (
    input wire logic i_clk,                        // core clock
    input wire logic i_req,                        // read request
    input wire logic [63:0] i_addr,                // entry address
    input wire logic [3:0] i_wait,                 // cycles before answer
    output logic o_ack,                            // answer pulse
    output logic [63:0] o_data                     // entry or junk
);
    logic [63:0] store [logic [63:0]];
    int n_reads = 0;
    int cnt = 0;
    // load one entry
    function automatic void put(input logic [63:0] a, input logic [63:0] d);
        store[a] = d;
    endfunction
    // answer after the wait, junk data between answers
    always @(posedge i_clk)
    begin
        #2;
        if (i_req && cnt >= int'(i_wait))
        begin
            o_ack = 1'b1;
            o_data = store.exists(i_addr) ? store[i_addr] : 64'h0;
            n_reads++;
            cnt = 0;
        end
        else
        begin
            o_ack = 1'b0;
            o_data = ~o_data;
            cnt = i_req ? cnt + 1 : 0;
        end
    end
    initial
    begin
        o_ack = 1'b0;
        o_data = 64'h0;
    end
endmodule

// file: bench/tb_reduced_table_translation_walker.sv
// self-checking bench for the reduced table walker
// assumes walker, package, checker and table memory model compiled first
`timescale 1ns/1ps
module tb_reduced_table_translation_walker;
    logic i_clk, i_reset_n, i_req, i_current_mode_bit, o_busy, o_done, o_fault;
    logic o_ordinary_walk, o_no_barrier_flag, i_reduced_table_mode_avail;
    logic i_reduced_table_mode_en, i_boundary_in_use, i_space_tag_load, i_inv_all;
    logic i_inv_private, i_inv_one, o_tag_out_of_range, o_mem_req, i_mem_ack;
    logic [1:0] i_access;
    logic [2:0] o_fault_type_code;
    logic [3:0] mem_wait;
    logic [15:0] i_space_tag;
    logic [27:0] i_table_base, i_system_table_base;
    logic [63:0] i_va, o_pa, i_virtual_boundary, i_inv_va, o_mem_addr, i_mem_data;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int rd;
    localparam logic [63:0] VA1 = 64'h0000_4000_0000_1234;
    localparam logic [63:0] VA2 = 64'h0000_4400_0000_0000;
    localparam logic [15:0] BITS [9] = '{16'h1161, 16'h02e1, 16'h0161, 16'h0161,
        16'h0160, 16'h0163, 16'h1165, 16'h0169, 16'h2271};
    localparam logic [1:0] ACC [9] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1};
    localparam logic [2:0] CODE [9] = '{3'h7, 3'h7, 3'h1, 3'h1, 3'h0, 3'h2, 3'h4, 3'h3, 3'h7};
    localparam logic [8:0] USER = 9'h10a;
    reduced_table_translation_walker i_dut (.i_clk, .i_reset_n, .i_req, .i_va, .i_access,
        .i_current_mode_bit, .o_busy, .o_done, .o_fault, .o_fault_type_code, .o_pa,
        .o_ordinary_walk, .o_no_barrier_flag, .i_reduced_table_mode_avail,
        .i_reduced_table_mode_en, .i_boundary_in_use, .i_virtual_boundary, .i_table_base,
        .i_system_table_base, .i_space_tag, .i_space_tag_load, .i_inv_all, .i_inv_private,
        .i_inv_one, .i_inv_va, .o_tag_out_of_range, .o_mem_req, .o_mem_addr, .i_mem_ack,
        .i_mem_data);
    rtw_table_memory i_mem (.i_clk(i_clk), .i_req(o_mem_req), .i_addr(o_mem_addr),
        .i_wait(mem_wait), .o_ack(i_mem_ack), .o_data(i_mem_data));
    always #20 i_clk = ~i_clk;
    // hang guard
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            results();
        end
    end
    function automatic logic [63:0] ent(input logic [27:0] frm, input logic [15:0] b);
        return {4'h0, frm, 16'h0, b};
    endfunction
    // entry address with 64KB table pages
    function automatic logic [63:0] at(input logic [27:0] frm, input logic [12:0] idx);
        return {20'h0, frm, 16'h0} | {48'h0, idx, 3'h0};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one translation, waits for the answer pulse
    task automatic go(input logic [63:0] va, input logic [1:0] acc, input logic user);
        int k;
        rd = i_mem.n_reads;
        i_va = va;
        i_access = acc;
        i_current_mode_bit = user;
        i_req = 1'b1;
        @(posedge i_clk) #1;
        i_req = 1'b0;
        for (k = 0; k < 40 && o_done !== 1'b1; k++)
            @(posedge i_clk) #1;
        check(o_done, 1'b1);
    endtask
    task automatic res(input logic [2:0] code, input logic [63:0] pa);
        check(o_fault, code != 3'h7);
        if (code != 3'h7)
            check(o_fault_type_code, code);
        else
            check(o_pa, pa);
    endtask
    task automatic results();
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {i_clk, i_reset_n, i_req, i_current_mode_bit, i_space_tag_load} = 5'h0;
        {i_inv_all, i_inv_private, i_inv_one, i_boundary_in_use} = 4'h0;
        {i_reduced_table_mode_avail, i_reduced_table_mode_en} = 2'h3;
        {i_access, mem_wait, i_space_tag} = '0;
        {i_va, i_virtual_boundary, i_inv_va} = '0;
        i_table_base = 28'h10;
        i_system_table_base = 28'h20;
        i_mem.put(at(28'h10, 13'h10), ent(28'h100, 16'h0001));
        i_mem.put(at(28'h20, 13'h11), ent(28'h0, 16'h0100));
        for (int k = 0; k < 9; k++)
            i_mem.put(at(28'h100, 13'(k)), ent(28'(8192 * (k + 1)), BITS[k]));
        repeat (16) @(posedge i_clk);
        #1 i_reset_n = 1'b1;
        go(64'h0000_1000_0000_0000, 2'h0, 1'b0);
        check(o_ordinary_walk, 1'b1);
        i_reduced_table_mode_en = 1'b0;
        go(VA1, 2'h0, 1'b0);
        check(o_ordinary_walk, 1'b1);
        i_reduced_table_mode_en = 1'b1;
        go(64'h8000_4000_0000_0000, 2'h0, 1'b0);
        res(3'h1, 64'h0);
        check(64'(i_mem.n_reads - rd), 64'h0);
        // protection, validity and fault-on cases, prompt and slow memory
        for (int k = 0; k < 9; k++)
        begin
            mem_wait = k[0] ? 4'h3 : 4'h0;
            go(VA1 | (64'(k) << 29), ACC[k], USER[k]);
            res(CODE[k], {4'h0, 28'(8192 * (k + 1)), 16'h0} | {35'h0, VA1[28:0]});
            if (CODE[k] == 3'h7)
                check(o_no_barrier_flag, BITS[k][7]);
        end
        go(VA1, 2'h0, 1'b0);
        check(64'(i_mem.n_reads - rd), 64'h0);
        go(VA1 | (64'h4 << 29), 2'h0, 1'b0);
        check(64'(i_mem.n_reads - rd), 64'h2);
        i_inv_private = 1'b1;
        @(posedge i_clk) #1;
        i_inv_private = 1'b0;
        go(VA1 | (64'h8 << 29), 2'h1, 1'b1);
        check(64'(i_mem.n_reads - rd), 64'h0);
        go(VA1, 2'h0, 1'b0);
        check(64'(i_mem.n_reads - rd), 64'h2);
        i_inv_all = 1'b1;
        @(posedge i_clk) #1;
        i_inv_all = 1'b0;
        go(VA1 | (64'h8 << 29), 2'h1, 1'b1);
        check(64'(i_mem.n_reads - rd), 64'h2);
        // invalid first entries, primary then alternate base
        i_virtual_boundary = VA2;
        go(VA2, 2'h0, 1'b0);
        res(3'h1, 64'h0);
        i_boundary_in_use = 1'b1;
        go(VA2, 2'h0, 1'b0);
        res(3'h0, 64'h0);
        // single page drop after a table change, then a new space tag
        go(VA1, 2'h0, 1'b0);
        i_mem.put(at(28'h100, 13'h0), ent(28'h6000, 16'h1161));
        i_inv_va = VA1;
        i_inv_one = 1'b1;
        @(posedge i_clk) #1;
        i_inv_one = 1'b0;
        go(VA1, 2'h0, 1'b0);
        check(64'(i_mem.n_reads - rd), 64'h2);
        res(3'h7, {20'h0, 28'h6000, 16'h0} | 64'h1234);
        i_space_tag = 16'h0005;
        i_space_tag_load = 1'b1;
        @(posedge i_clk) #1;
        i_space_tag_load = 1'b0;
        go(VA1, 2'h0, 1'b0);
        check(64'(i_mem.n_reads - rd), 64'h2);
        go(VA1 | (64'h8 << 29), 2'h1, 1'b1);
        check(64'(i_mem.n_reads - rd), 64'h0);
        i_space_tag = 16'h0100;
        @(posedge i_clk) #1;
        check(o_tag_out_of_range, 1'b1);
        i_space_tag = 16'h00ff;
        @(posedge i_clk) #1;
        check(o_tag_out_of_range, 1'b0);
        results();
    end
endmodule
bind reduced_table_translation_walker rtw_walker_properties #(.VA_SIZE(VA_SIZE),
    .TAG_BITS(TAG_BITS), .SPACE_TAG_LIMIT(SPACE_TAG_LIMIT)) i_props (.i_clk, .i_reset_n,
    .i_req, .i_va, .i_reduced_table_mode_avail, .i_reduced_table_mode_en, .i_boundary_in_use,
    .i_virtual_boundary, .i_table_base, .i_system_table_base, .i_space_tag, .o_busy, .o_done,
    .o_fault, .o_fault_type_code, .o_pa, .o_ordinary_walk, .o_tag_out_of_range, .o_mem_req,
    .o_mem_addr, .i_mem_ack, .i_mem_data);
